// file: logic/vbg_pkg.sv
package vbg_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0]  VBG_CTRL_OFS   = 8'h00; // steering control
    localparam logic [7:0]  VBG_FLAGS_OFS  = 8'h04; // live flags, read only
    localparam logic [7:0]  VBG_STAT_OFS   = 8'h08; // sticky events
    localparam logic [7:0]  VBG_MASK_OFS   = 8'h0C; // interrupt mask
    localparam logic [31:0] VBG_CTRL_RST   = 32'h0000_0003;
    localparam logic [31:0] VBG_MASK_RST   = 32'h0000_0000;
    // control bit positions
    localparam int VBG_CTRL_OVF_EN  = 0; // overflow check enable
    localparam int VBG_CTRL_MARK_EN = 1; // function byte mark enable
    // flags bit positions
    localparam int VBG_FL_FIRST  = 0;
    localparam int VBG_FL_DIGIT  = 1;
    localparam int VBG_FL_SECOND = 2;
    localparam int VBG_FL_SAME   = 3;
    localparam int VBG_FL_ZERO   = 4;
    localparam int VBG_FL_OVF    = 5;
    // status and mask bit positions
    localparam int VBG_EV_OVF  = 0; // overflow interrupt raised
    localparam int VBG_EV_MARK = 1; // mark sequence entered
    localparam int VBG_EV_W    = 2;

    // ----------------------------------------
    // types
    // ----------------------------------------
    // one byte with its parity bit
    typedef struct packed {
        logic       par;
        logic [7:0] dat;
    } vbg_byte_t;

    // operation class from execution control
    typedef enum logic [1:0] {
        VBG_OP_OTHER = 2'h0,
        VBG_OP_DEC   = 2'h1, // add, subtract, zero-and-add
        VBG_OP_TRT   = 2'h3  // translate-and-test scan
    } vbg_op_t;

    // per-cycle commands from execution control
    typedef struct packed {
        logic    set_first;   // first-operand select on
        logic    clr_first;
        logic    set_digit;   // digit buffer select on
        logic    clr_digit;
        logic    set_second;  // second-operand word on
        logic    clr_second;
        logic    set_same;    // same-word (overlap) on
        logic    final_cyc;   // final execute cycle
        logic    hi_en;       // left high digit gate
        logic    lo_en;       // left low digit gate
        logic    op1_done;    // all first-operand bytes done
        logic    fn_check;    // test function byte
        logic    sign_fixup;  // sign fixup sequence cycle
        vbg_op_t op;
    } vbg_ctl_t;
endpackage

// file: logic/vbg_byte_gating.sv
`timescale 1ns/1ps
//
// Behaviour
// - left selector passes one byte, first word or buffer
// - first select picks word byte by first pointer
// - control sets first select when byte needed
// - digit select routes buffer byte to adder
// - left select flags mutually exclusive
// - left digits gated independently to adder
// - right selector passes byte by second pointer
// - same word uses first register, other off
// - second-word flag set and reset by control
// - final cycle clears both right flags
// - overlap sets the same-word flag
// - right select flags mutually exclusive
// - zero latch set when both digits zero
// - nonzero function byte enters mark, ends
// - nonzero leftover byte sets overflow pending
module vbg_byte_gating
    import vbg_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // operand sources
    input  wire vbg_byte_t [7:0]  first_word,
    input  wire vbg_byte_t [7:0]  second_word,
    input  wire vbg_byte_t        digit_buffer_counter,
    input  wire logic [2:0]       first_ptr,
    input  wire logic [2:0]       second_ptr,
    // execution control
    input  wire vbg_ctl_t         ctl,
    // to adder and logical unit
    output vbg_byte_t             left_byte_selector,
    output logic      [3:0]       adder_left_hi,
    output logic      [3:0]       adder_left_lo,
    output vbg_byte_t             right_byte_selector,
    output logic                  right_zero,
    output logic                  overflow_pending_flag,
    output logic                  mark_start,
    output logic                  end_instr,
    output logic                  overflow_irq,
    // interrupt
    output logic                  irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic            first_sel_r;   // first-operand select
    logic            digit_sel_r;   // digit buffer select
    logic            second_sel_r;  // second-operand word
    logic            same_sel_r;    // same-word select
    logic            zero_r;        // right byte zero latch
    logic            ovf_r;         // overflow pending
    logic [31:0]     ctrl_r;        // control register
    logic [VBG_EV_W-1:0] stat_r;    // sticky events
    logic [VBG_EV_W-1:0] mask_r;    // interrupt mask
    logic [31:0]     rdata_nxt;     // read mux
    logic            hit;           // mapped address
    logic            acc;           // completing access
    logic            ev_ovf;        // overflow raised now
    logic            ev_mark;       // mark entered now
    vbg_byte_t       lb_c;          // left selector value
    vbg_byte_t       rb_c;          // right selector value
    logic            rb_zero_c;     // both right digits zero

    // ----------------------------------------
    // selectors
    // ----------------------------------------
    // left and right byte muxes
    always_comb begin
        lb_c = '0;
        if (first_sel_r) begin
            lb_c = first_word[first_ptr];
        end else if (digit_sel_r) begin
            lb_c = digit_buffer_counter;
        end
        rb_c = '0;
        if (same_sel_r) begin
            rb_c = first_word[second_ptr];
        end else if (second_sel_r) begin
            rb_c = second_word[second_ptr];
        end
        rb_zero_c = (rb_c.dat[7:4] == 4'h0) && (rb_c.dat[3:0] == 4'h0);
    end

    // ----------------------------------------
    // left gating flags
    // ----------------------------------------
    // set of one is reset of the other; first wins a tie
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_sel_r <= 1'b0;
            digit_sel_r <= 1'b0;
        end else if (ctl.set_first) begin
            first_sel_r <= 1'b1;
            digit_sel_r <= 1'b0;
        end else if (ctl.set_digit) begin
            digit_sel_r <= 1'b1;
            first_sel_r <= 1'b0;
        end else begin
            if (ctl.clr_first) begin
                first_sel_r <= 1'b0;
            end
            if (ctl.clr_digit) begin
                digit_sel_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // right gating flags
    // ----------------------------------------
    // final cycle beats every set; overlap beats word set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_sel_r <= 1'b0;
            same_sel_r   <= 1'b0;
        end else if (ctl.final_cyc) begin
            second_sel_r <= 1'b0;
            same_sel_r   <= 1'b0;
        end else if (ctl.set_same) begin
            same_sel_r   <= 1'b1;
            second_sel_r <= 1'b0;
        end else if (ctl.set_second) begin
            second_sel_r <= 1'b1;
            same_sel_r   <= 1'b0;
        end else if (ctl.clr_second) begin
            second_sel_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // datapath outputs
    // ----------------------------------------
    // registered bytes and split digit gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_byte_selector  <= '0;
            right_byte_selector <= '0;
            adder_left_hi       <= 4'h0;
            adder_left_lo       <= 4'h0;
        end else begin
            left_byte_selector  <= lb_c;
            right_byte_selector <= rb_c;
            adder_left_hi <= ctl.hi_en ? lb_c.dat[7:4] : 4'h0;
            adder_left_lo <= ctl.lo_en ? lb_c.dat[3:0] : 4'h0;
        end
    end

    // zero latch follows the byte each cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_r <= 1'b0;
        end else begin
            zero_r <= rb_zero_c;
        end
    end

    // ----------------------------------------
    // sequencing events
    // ----------------------------------------
    assign ev_mark = (ctl.op == VBG_OP_TRT) && ctl.fn_check && !zero_r
                     && ctrl_r[VBG_CTRL_MARK_EN];
    assign ev_ovf  = ctl.sign_fixup && ovf_r;

    // overflow pending; a set beats the final-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_r <= 1'b0;
        end else if ((ctl.op == VBG_OP_DEC) && ctl.op1_done && !rb_zero_c
                     && ctrl_r[VBG_CTRL_OVF_EN]) begin
            ovf_r <= 1'b1;
        end else if (ctl.final_cyc) begin
            ovf_r <= 1'b0;
        end
    end

    // mark start, end and overflow pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mark_start   <= 1'b0;
            end_instr    <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            mark_start   <= ev_mark;
            end_instr    <= ev_mark;
            overflow_irq <= ev_ovf;
        end
    end

    // flag mirrors for the outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            right_zero            <= 1'b0;
            overflow_pending_flag <= 1'b0;
        end else begin
            right_zero            <= rb_zero_c;
            overflow_pending_flag <= ovf_r;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign hit = (paddr == VBG_CTRL_OFS) || (paddr == VBG_FLAGS_OFS) ||
                 (paddr == VBG_STAT_OFS) || (paddr == VBG_MASK_OFS);
    assign acc = psel && penable && pready;

    // read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr)
            VBG_CTRL_OFS:  rdata_nxt = ctrl_r;
            VBG_FLAGS_OFS: rdata_nxt = {26'h0, ovf_r, zero_r, same_sel_r,
                                        second_sel_r, digit_sel_r, first_sel_r};
            VBG_STAT_OFS:  rdata_nxt = {30'h0, stat_r};
            VBG_MASK_OFS:  rdata_nxt = {30'h0, mask_r};
            default:       rdata_nxt = 32'h0000_0000;
        endcase
    end

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && !pwrite) ? rdata_nxt : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !hit;
        end
    end

    // writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= VBG_CTRL_RST;
            mask_r <= VBG_MASK_RST[VBG_EV_W-1:0];
        end else if (acc && pwrite) begin
            if (paddr == VBG_CTRL_OFS) begin
                ctrl_r <= pwdata;
            end
            if (paddr == VBG_MASK_OFS) begin
                mask_r <= pwdata[VBG_EV_W-1:0];
            end
        end
    end

    // sticky events, cleared by read, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
        end else begin
            // clear only what the read returned; a later event survives
            if (acc && !pwrite && (paddr == VBG_STAT_OFS)) begin
                stat_r <= stat_r & ~prdata[VBG_EV_W-1:0];
            end
            if (ev_ovf) begin
                stat_r[VBG_EV_OVF] <= 1'b1;
            end
            if (ev_mark) begin
                stat_r[VBG_EV_MARK] <= 1'b1;
            end
        end
    end

    // level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // candidate bytes one cycle back, for the path checks
    vbg_byte_t       exp_first_r;   // first word byte under first pointer
    vbg_byte_t       exp_same_r;    // first word byte under second pointer

    // sample the candidates beside the real selectors
    always_ff @(posedge pclk) begin
        exp_first_r <= first_word[first_ptr];
        exp_same_r  <= first_word[second_ptr];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_left_flags_excl: assert property (!(first_sel_r && digit_sel_r))
        else $error("left select flags both on");
    a_right_flags_excl: assert property (!(second_sel_r && same_sel_r))
        else $error("right select flags both on");
    a_final_clears: assert property (ctl.final_cyc |=> !second_sel_r && !same_sel_r)
        else $error("right flags survive final cycle");
    a_first_byte_path: assert property (first_sel_r |=>
        left_byte_selector == exp_first_r)
        else $error("first word byte not passed");
    a_digit_byte_path: assert property (!first_sel_r && digit_sel_r |=>
        left_byte_selector == $past(digit_buffer_counter))
        else $error("digit buffer byte not passed");
    a_digit_split: assert property (!ctl.hi_en && ctl.lo_en |=>
        adder_left_hi == 4'h0 && adder_left_lo == left_byte_selector.dat[3:0])
        else $error("digit gates not independent");
    a_same_word_path: assert property (same_sel_r |=>
        right_byte_selector == exp_same_r)
        else $error("overlap byte not from first word");
    a_zero_latch: assert property ($past(presetn) |-> zero_r ==
        (right_byte_selector.dat == 8'h00))
        else $error("zero latch wrong");
    a_ovf_pending: assert property (ctl.op == VBG_OP_DEC && ctl.op1_done &&
        !rb_zero_c && ctrl_r[VBG_CTRL_OVF_EN] |=> ovf_r ##1 overflow_pending_flag)
        else $error("overflow pending not set");
    a_trt_mark: assert property (ev_mark |=> mark_start && end_instr)
        else $error("mark sequence not entered");
    a_irq_high: assert property ((|(stat_r & mask_r)) |=> irq)
        else $error("interrupt not raised");
    a_irq_low: assert property (!(|(stat_r & mask_r)) |=> !irq)
        else $error("interrupt not dropped");
    a_mark_sticky: assert property (ev_mark |=> stat_r[VBG_EV_MARK])
        else $error("mark event not recorded");
    a_ovf_fixup: assert property (ctl.sign_fixup && ovf_r |=> overflow_irq)
        else $error("overflow interrupt missing");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over two cycles");

    c_overlap: cover property (second_sel_r ##1 same_sel_r);
    c_mark: cover property (mark_start);
    c_ovf_irq: cover property (ovf_r ##[1:20] overflow_irq);
    c_digit_move: cover property (digit_sel_r ##1 first_sel_r);
    c_zero_scan: cover property (ctl.fn_check && zero_r);

endmodule

// file: verification/vbg_exec_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// execution control stand-in
// ----------------------------------------
// issues one-cycle commands over held levels, changing ctl only
// just after a rising edge so the gating block samples it cleanly
module vbg_exec_model
    import vbg_pkg::*;
(
    // clock
    input  wire logic pclk,
    // commands to the gating block
    output vbg_ctl_t  ctl
);
    vbg_ctl_t base_r; // levels held between commands (gates, op class)

    // quiet at time zero
    initial begin
        base_r = '0;
        ctl    = '0;
    end

    // change the held levels
    task automatic hold(input vbg_ctl_t c);
        @(posedge pclk);
        base_r <= c;
        ctl    <= c;
    endtask

    // one-cycle command on top of the held levels
    task automatic cmd(input vbg_ctl_t c);
        @(posedge pclk);
        ctl <= c | base_r;
        @(posedge pclk);
        ctl <= base_r;
    endtask
endmodule

// file: verification/vbg_byte_gating_tb.sv
`timescale 1ns/1ps
module vbg_byte_gating_tb
    import vbg_pkg::*;
;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic            pclk    = 1'b0;
    logic            presetn = 1'b0;
    logic            psel    = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite  = 1'b0;
    logic [7:0]      paddr   = '0;
    logic [31:0]     pwdata  = '0;
    logic [31:0]     prdata, rd;
    logic            pready, pslverr, er;
    vbg_byte_t [7:0] first_word, second_word;
    vbg_byte_t       digit_buffer_counter, left_byte_selector, right_byte_selector;
    logic [2:0]      first_ptr  = '0;
    logic [2:0]      second_ptr = '0;
    vbg_ctl_t        ctl;
    logic [3:0]      adder_left_hi, adder_left_lo;
    logic            right_zero, overflow_pending_flag, mark_start, end_instr;
    logic            overflow_irq, irq;
    int              err_total = 0;
    int              compares  = 0;
    localparam vbg_op_t OT = VBG_OP_OTHER;

    always #10 pclk = ~pclk; // 50 MHz

    vbg_byte_gating i_vbg_byte_gating (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .first_word, .second_word, .digit_buffer_counter, .first_ptr,
        .second_ptr, .ctl, .left_byte_selector, .adder_left_hi, .adder_left_lo,
        .right_byte_selector, .right_zero, .overflow_pending_flag, .mark_start,
        .end_instr, .overflow_irq, .irq
    );
    vbg_exec_model i_vbg_exec_model (.pclk, .ctl);

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one apb transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // command pulse, then let it reach the outputs
    task automatic go(input vbg_ctl_t c);
        i_vbg_exec_model.cmd(c);
    endtask
    task automatic st();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    // watch six cycles for a pulse (0 mark, 1 overflow interrupt)
    task automatic seen(input int s, input logic exp);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 6; n++) begin
            #1;
            if ((s == 0 ? mark_start : overflow_irq) === 1'b1 && !hit) begin
                hit = 1'b1;
                chk(end_instr, (s == 0) ? 32'h1 : 32'h0);
            end
            @(posedge pclk);
        end
        chk(hit, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset values and a refused address
    task automatic t_reset();
        #1;
        chk(left_byte_selector, 32'h0);
        apb(1'b0, VBG_CTRL_OFS, '0);
        chk(rd, VBG_CTRL_RST);
        apb(1'b0, VBG_MASK_OFS, '0);
        chk(rd, VBG_MASK_RST);
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk(rd & 32'h2F, 32'h0);
        apb(1'b0, 8'h10, '0);
        chk({rd[30:0], er}, 32'h1);
    endtask

    // left selector over every pointer, buffer path, digit gates
    task automatic t_left();
        i_vbg_exec_model.hold('{hi_en: 1'b1, op: OT, default: 1'b0});
        go('{set_first: 1'b1, op: OT, default: 1'b0});
        for (int k = 0; k < 8; k++) begin
            @(posedge pclk);
            first_ptr <= 3'(k);
            st();
            chk(left_byte_selector, first_word[k]);
            chk(adder_left_hi, first_word[k].dat[7:4]);
            chk(adder_left_lo, 32'h0);
        end
        go('{set_digit: 1'b1, op: OT, default: 1'b0});
        st();
        chk(left_byte_selector, digit_buffer_counter);
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk(rd & 32'h3, 32'h2);
        i_vbg_exec_model.hold('{lo_en: 1'b1, op: OT, default: 1'b0});
        st();
        chk({adder_left_hi, adder_left_lo}, 32'h0C);
        go('{set_first: 1'b1, op: OT, default: 1'b0});
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk(rd & 32'h3, 32'h1);
        st();
        chk(left_byte_selector, first_word[7]);
    endtask

    // right selector flags, overlap, zero latch
    task automatic t_right();
        @(posedge pclk);
        second_ptr <= 3'h5;
        go('{set_second: 1'b1, op: OT, default: 1'b0});
        st();
        chk(right_byte_selector, second_word[5]);
        chk(right_zero, 32'h0);
        @(posedge pclk);
        second_ptr <= 3'h0;
        st();
        chk({right_byte_selector, right_zero}, {second_word[0], 1'b1});
        go('{set_same: 1'b1, op: OT, default: 1'b0});
        st();
        chk(right_byte_selector, first_word[0]);
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk((rd >> 2) & 32'h3, 32'h2);
        go('{set_second: 1'b1, op: OT, default: 1'b0});
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk((rd >> 2) & 32'h3, 32'h1);
        go('{clr_second: 1'b1, op: OT, default: 1'b0});
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk((rd >> 2) & 32'h3, 32'h0);
        go('{set_same: 1'b1, op: OT, default: 1'b0});
        go('{final_cyc: 1'b1, op: OT, default: 1'b0});
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk((rd >> 2) & 32'h3, 32'h0);
    endtask

    // function byte scan: nonzero marks and ends, zero goes on
    task automatic t_mark();
        apb(1'b1, VBG_MASK_OFS, 32'h2);
        @(posedge pclk);
        second_ptr <= 3'h5;
        go('{set_second: 1'b1, op: OT, default: 1'b0});
        i_vbg_exec_model.hold('{op: VBG_OP_TRT, default: 1'b0});
        st();
        go('{fn_check: 1'b1, op: OT, default: 1'b0});
        seen(0, 1'b1);
        chk(irq, 32'h1);
        apb(1'b0, VBG_STAT_OFS, '0);
        chk(rd & 32'h3, 32'h2);
        apb(1'b0, VBG_STAT_OFS, '0);
        chk(rd & 32'h3, 32'h0);
        st();
        chk(irq, 32'h0);
        @(posedge pclk);
        second_ptr <= 3'h0;
        st();
        go('{fn_check: 1'b1, op: OT, default: 1'b0});
        seen(0, 1'b0);
    endtask

    // leftover second-operand byte check and overflow interrupt
    task automatic t_ovf();
        i_vbg_exec_model.hold('{op: VBG_OP_DEC, default: 1'b0});
        go('{op1_done: 1'b1, op: OT, default: 1'b0});
        st();
        chk(overflow_pending_flag, 32'h0);
        @(posedge pclk);
        second_ptr <= 3'h5;
        st();
        go('{op1_done: 1'b1, op: OT, default: 1'b0});
        st();
        chk(overflow_pending_flag, 32'h1);
        go('{sign_fixup: 1'b1, op: OT, default: 1'b0});
        seen(1, 1'b1);
        apb(1'b0, VBG_STAT_OFS, '0);
        chk(rd & 32'h3, 32'h1);
        go('{final_cyc: 1'b1, op: OT, default: 1'b0});
        st();
        chk(overflow_pending_flag, 32'h0);
    endtask

    // reset in mid-run clears flags and restores control
    task automatic t_rerun();
        apb(1'b1, VBG_CTRL_OFS, 32'h0);
        go('{set_second: 1'b1, op: OT, default: 1'b0});
        go('{op1_done: 1'b1, op: OT, default: 1'b0});
        st();
        chk(overflow_pending_flag, 32'h0);
        go('{set_first: 1'b1, op: OT, default: 1'b0});
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk(left_byte_selector, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, VBG_FLAGS_OFS, '0);
        chk(rd & 32'h2F, 32'h0);
        apb(1'b0, VBG_CTRL_OFS, '0);
        chk(rd, VBG_CTRL_RST);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            first_word[i]  = '{par: i[0], dat: 8'hA0 + 8'(i)};
            second_word[i] = '{par: ~i[0], dat: 8'(i) * 8'h11};
        end
        digit_buffer_counter = '{par: 1'b1, dat: 8'h3C};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_left();
        t_right();
        t_mark();
        t_ovf();
        t_rerun();
        summarize();
    end
    initial begin
        #200000;
        err_total++;
        summarize();
    end
endmodule
